// ---- hdl/alrc_cfg.sv ----
// configuration decode for load response and phase functions
`timescale 1ns/1ns
`default_nettype none
`include "alrc_map.svh"
module alrc_cfg (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [`ALRC_NVM_W-1:0] nvm_word_i,
    input  wire logic                   nvm_valid_i,
    input  wire logic [4:0]             lin_blind_zone_i,
    input  wire logic                   lrc_active_i,
    input  wire logic                   pre_to_reg_i,
    input  wire logic                   phase_reg_i,
    input  wire logic                   emergency_start_i,
    input  wire logic [9:0]             loop_duty_i,
    input  wire logic [9:0]             applied_duty_i,
    input  wire logic [9:0]             filt_duty_i,
    input  wire logic [9:0]             raw_duty_i,
    input  wire logic                   phase_period_i,
    input  wire logic                   speed_above_lrc_i,
    input  wire logic                   speed_above_start_i,
    input  wire logic                   speed_above_hot_i,
    input  wire logic [12:0]            prog_start_rpm_i,
    input  wire logic [9:0]             phase_sample_i,
    input  wire logic                   pwm_period_i,
    input  wire logic                   lrc_request_i,
    output var  logic                   cfg_ready_o,
    output var  logic [2:0]             lrc_rise_time_s_o,
    output var  logic [12:0]            lrc_cutoff_rpm_o,
    output var  logic [2:0]             lrc_neg_gradient_time_o,
    output var  logic [9:0]             lrc_start_duty_o,
    output var  logic [9:0]             lin_duty_o,
    output var  logic [9:0]             lrc_cmp_duty_o,
    output var  logic [3:0]             duty_filter_time_sel_o,
    output var  logic                   lrc_start_o,
    output var  logic [12:0]            self_start_rpm_o,
    output var  logic [7:0]             emergency_speed_idx_o,
    output var  logic                   lrc_speed_event_o,
    output var  logic                   start_speed_event_o,
    output var  logic                   hot_start_event_o,
    output var  logic [9:0]             phase_filt_o,
    output var  logic                   phase_high_only_o,
    output var  logic [2:0]             adaptive_floor_code_o,
    output var  logic                   overlimit_shutdown_enable_o,
    output var  logic                   phase_reg_ov_disable_o,
    output var  logic [9:0]             phase_reg_duty_cap_o
);
    // 0.1 % duty units throughout
    localparam logic [12:0] RPM_TAB [4] = '{13'h0BB8, 13'h0FA0,
                                            13'h12C0, 13'h1770};
    localparam logic [9:0]  CAP_TAB [8] = '{10'h037, 10'h078, 10'h0B4,
        10'h0F0, 10'h136, 10'h172, 10'h1AE, 10'h1F4};
    localparam int unsigned C50  = `ALRC_CLK_KHZ * `ALRC_MS_50;
    localparam int unsigned C100 = `ALRC_CLK_KHZ * `ALRC_MS_100;
    localparam int unsigned C300 = `ALRC_CLK_KHZ * `ALRC_MS_300;

    typedef struct packed {
        alrc_pkg::alrc_state_t st;
        logic [`ALRC_NVM_W-1:0] nvm;
        logic [2:0]  rise;
        logic [12:0] cut;
        logic [9:0]  start_duty;
        logic [9:0]  lin;
        logic [9:0]  cmp;
        logic [1:0]  dly;
        logic        lrc_start;
        logic        lrc_done;
        logic        start_evt;
        logic [27:0] rm_cnt;
        logic [9:0]  ph;
        logic [2:0]  floor;
        logic [9:0]  cap;
        logic [12:0] ss;
        logic [7:0]  idx;
    } alrc_st_t;
    alrc_st_t s_r;
    alrc_st_t s_nxt;

    function automatic logic [4:0] fld5(input logic [`ALRC_NVM_W-1:0] w,
                                        input int lsb);
        fld5 = 5'(w >> lsb);
    endfunction

    logic [4:0]  bz_code;
    logic [27:0] rm_len;
    logic        lrc_evt;
    logic        hot_evt;
    logic        st_evt_raw;
    logic [3:0]  lrc_need;
    logic [3:0]  hot_need;

    always_comb begin
        bz_code = s_r.nvm[`ALRC_BZEN_BIT] ? lin_blind_zone_i
                : fld5(s_r.nvm, `ALRC_BZ_LSB);
        lrc_need = {s_r.nvm[`ALRC_LRCNT_LSB +: 3], 1'b1};
        hot_need = {1'b0, s_r.nvm[`ALRC_HOT_LSB +: 3]};
        case (s_r.nvm[`ALRC_RMDLY_LSB +: 2])
            2'h1: rm_len = 28'(C50);
            2'h2: rm_len = 28'(C100);
            2'h3: rm_len = 28'(C300);
            default: rm_len = 28'h0;
        endcase
    end

    alrc_evt_filter u_lrc_filt (
        .mclk_i   (mclk_i),
        .rst_b_i  (rst_b_i),
        .bypass_i (s_r.nvm[`ALRC_BYP_BIT]),
        .need_i   (lrc_need),
        .period_i (phase_period_i),
        .cond_i   (speed_above_lrc_i && s_r.st == alrc_pkg::ALRC_ST_RUN),
        .event_o  (lrc_evt)
    );
    alrc_evt_filter u_hot_filt (
        .mclk_i   (mclk_i),
        .rst_b_i  (rst_b_i),
        .bypass_i (s_r.nvm[`ALRC_BYP_BIT]),
        .need_i   (hot_need),
        .period_i (phase_period_i),
        .cond_i   (speed_above_hot_i && s_r.st == alrc_pkg::ALRC_ST_RUN),
        .event_o  (hot_evt)
    );
    assign st_evt_raw = speed_above_start_i;

    always_comb begin
        s_nxt = s_r;
        s_nxt.lrc_start = 1'b0;
        case (s_r.st)
            alrc_pkg::ALRC_ST_IDLE: begin
                s_nxt.st = alrc_pkg::ALRC_ST_LOAD;
            end
            alrc_pkg::ALRC_ST_LOAD: begin
                if (nvm_valid_i) begin
                    s_nxt.nvm = nvm_word_i;
                    if (nvm_word_i[`ALRC_RISE_LSB +: 3] > `ALRC_RISE_MAX) begin
                        s_nxt.nvm[`ALRC_RISE_LSB +: 3] = `ALRC_RISE_DEF;
                    end
                    s_nxt.st = alrc_pkg::ALRC_ST_RUN;
                end
            end
            alrc_pkg::ALRC_ST_RUN: begin
                s_nxt.rise = s_r.nvm[`ALRC_RISE_LSB +: 3] + 3'h1;
                s_nxt.cut = RPM_TAB[s_r.nvm[`ALRC_CUT_LSB +: 2]];
                s_nxt.start_duty = (lrc_active_i && pre_to_reg_i
                    && s_r.nvm[`ALRC_Q25_BIT]) ? `ALRC_DUTY_Q25
                    : 10'(bz_code * `ALRC_BZ_STEP);
                s_nxt.cmp = s_r.nvm[`ALRC_SENS_BIT] ? raw_duty_i
                          : filt_duty_i;
                if (phase_reg_i) begin
                    case (s_r.nvm[`ALRC_PHREP_LSB +: 2])
                        2'h1: s_nxt.lin = `ALRC_DUTY_Q25;
                        2'h2: s_nxt.lin = `ALRC_DUTY_ZERO;
                        2'h3: s_nxt.lin = applied_duty_i;
                        default: s_nxt.lin = loop_duty_i;
                    endcase
                end else if (lrc_active_i && s_r.nvm[`ALRC_REPSRC_BIT]) begin
                    s_nxt.lin = applied_duty_i;
                end else begin
                    s_nxt.lin = loop_duty_i;
                end
                // start delay in PWM periods
                // a separate done flag keeps all four delay codes usable
                if (!lrc_request_i) begin
                    s_nxt.dly = s_r.nvm[`ALRC_DLY_LSB +: 2];
                    s_nxt.lrc_done = 1'b0;
                end else if (!s_r.lrc_done) begin
                    if (s_r.dly == 2'h0) begin
                        s_nxt.lrc_start = 1'b1;
                        s_nxt.lrc_done = 1'b1;
                    end else if (pwm_period_i) begin
                        s_nxt.dly = s_r.dly - 2'h1;
                    end
                end
                if (st_evt_raw) begin
                    s_nxt.start_evt = 1'b1;
                    s_nxt.rm_cnt = 28'h0;
                end else if (s_r.start_evt) begin
                    if (s_r.rm_cnt >= rm_len) begin
                        s_nxt.start_evt = 1'b0;
                    end else begin
                        s_nxt.rm_cnt = s_r.rm_cnt + 28'h1;
                    end
                end
                if (s_r.nvm[`ALRC_LPF_BIT]) begin
                    // round toward the sample so a step settles exactly
                    s_nxt.ph = 10'(({1'b0, s_r.ph} + {1'b0, phase_sample_i}
                               + {10'h0, phase_sample_i > s_r.ph}) >> 1);
                end else begin
                    s_nxt.ph = phase_sample_i;
                end
                s_nxt.floor = (s_r.nvm[`ALRC_FMODE_BIT] || emergency_start_i)
                    ? s_r.nvm[`ALRC_FEMR_LSB +: 3]
                    : {1'b0, s_r.nvm[`ALRC_FBAND_LSB +: 2]};
                s_nxt.cap = CAP_TAB[s_r.nvm[`ALRC_CAP_LSB +: 3]];
                s_nxt.ss = s_r.nvm[`ALRC_SSSRC_BIT] ? `ALRC_RPM_4000
                         : prog_start_rpm_i;
                s_nxt.idx = `ALRC_IDX_BASE
                    - {s_r.nvm[`ALRC_EMC_LSB +: 6], 2'h0};
            end
            default: s_nxt.st = alrc_pkg::ALRC_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
            s_r.st <= alrc_pkg::ALRC_ST_IDLE;
            s_r.nvm[`ALRC_RISE_LSB +: 3] <= `ALRC_RISE_DEF;
            s_r.nvm[`ALRC_BZ_LSB +: 5] <= `ALRC_BZ_DEF;
            s_r.nvm[`ALRC_DLY_LSB +: 2] <= `ALRC_DLY_DEF;
            s_r.nvm[`ALRC_EMC_LSB +: 6] <= `ALRC_EMC_DEF;
            s_r.nvm[`ALRC_LRCNT_LSB +: 3] <= `ALRC_LRCNT_DEF;
            s_r.nvm[`ALRC_RMDLY_LSB +: 2] <= `ALRC_RMDLY_DEF;
            s_r.nvm[`ALRC_HOT_LSB +: 3] <= `ALRC_HOT_DEF;
            s_r.nvm[`ALRC_CAP_LSB +: 3] <= `ALRC_CAP_DEF;
            s_r.nvm[`ALRC_OVSD_BIT] <= `ALRC_OVSD_DEF;
            s_r.nvm[`ALRC_PROV_BIT] <= `ALRC_PROV_DEF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state flip-flops
    always_comb begin
        cfg_ready_o = (s_r.st == alrc_pkg::ALRC_ST_RUN);
        lrc_rise_time_s_o = s_r.rise;
        lrc_cutoff_rpm_o = s_r.cut;
        lrc_neg_gradient_time_o = s_r.nvm[`ALRC_NEG_LSB +: 3];
        lrc_start_duty_o = s_r.start_duty;
        lin_duty_o = s_r.lin;
        lrc_cmp_duty_o = s_r.cmp;
        duty_filter_time_sel_o = s_r.nvm[`ALRC_FT_LSB +: 4];
        lrc_start_o = s_r.lrc_start;
        self_start_rpm_o = s_r.ss;
        emergency_speed_idx_o = s_r.idx;
        lrc_speed_event_o = lrc_evt;
        start_speed_event_o = s_r.start_evt;
        hot_start_event_o = hot_evt;
        phase_filt_o = s_r.ph;
        phase_high_only_o = s_r.nvm[`ALRC_HONLY_BIT];
        adaptive_floor_code_o = s_r.floor;
        overlimit_shutdown_enable_o = s_r.nvm[`ALRC_OVSD_BIT];
        phase_reg_ov_disable_o = s_r.nvm[`ALRC_PROV_BIT];
        phase_reg_duty_cap_o = s_r.cap;
    end

    AST_RISE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o |=> lrc_rise_time_s_o
            == 3'($past(s_r.nvm[`ALRC_RISE_LSB +: 3]) + 3'h1))
        else $error("rise time decode wrong");
    AST_IDX: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o |=> emergency_speed_idx_o
            + {$past(s_r.nvm[`ALRC_EMC_LSB +: 6]), 2'h0} == `ALRC_IDX_BASE)
        else $error("speed index wrong");
    AST_Q25: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o && lrc_active_i && pre_to_reg_i && s_r.nvm[`ALRC_Q25_BIT]
        |=> lrc_start_duty_o == `ALRC_DUTY_Q25)
        else $error("quarter start duty missing");
    AST_PHZ: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o && phase_reg_i && s_r.nvm[`ALRC_PHREP_LSB +: 2] == 2'h2
        |=> lin_duty_o == `ALRC_DUTY_ZERO)
        else $error("phase report zero wrong");
    AST_SENS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o && s_r.nvm[`ALRC_SENS_BIT]
        |=> lrc_cmp_duty_o == $past(raw_duty_i))
        else $error("sensitivity source wrong");
    AST_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        s_r.st == alrc_pkg::ALRC_ST_LOAD && nvm_valid_i |=> cfg_ready_o)
        else $error("load did not finish");
    AST_RM: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o && speed_above_start_i |=> start_speed_event_o)
        else $error("start event not raised");
    AST_SSR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o && s_r.nvm[`ALRC_SSSRC_BIT]
        |=> self_start_rpm_o == `ALRC_RPM_4000)
        else $error("fixed self-start speed wrong");
    AST_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        lrc_start_o |=> !lrc_start_o)
        else $error("start pulse longer than one cycle");
    AST_FLOOR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_ready_o && s_r.nvm[`ALRC_FMODE_BIT]
        |=> adaptive_floor_code_o == $past(s_r.nvm[`ALRC_FEMR_LSB +: 3]))
        else $error("forced emergency floor wrong");
    COV_LOAD: cover property (@(posedge mclk_i) cfg_ready_o);
    COV_START: cover property (@(posedge mclk_i) lrc_start_o);
    COV_HOT: cover property (@(posedge mclk_i) hot_start_event_o);
endmodule
`default_nettype wire

// ---- hdl/alrc_evt_filter.sv ----
// consecutive phase-period counter with optional bypass
`timescale 1ns/1ns
`default_nettype none
module alrc_evt_filter (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       bypass_i,
    input  wire logic [3:0] need_i,
    input  wire logic       period_i,
    input  wire logic       cond_i,
    output var  logic       event_o
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       evt;
    } alrc_ef_t;
    alrc_ef_t s_r;
    alrc_ef_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (bypass_i) begin
            s_nxt.evt = cond_i;
            s_nxt.cnt = 4'h0;
        end else if (!cond_i) begin
            s_nxt.cnt = 4'h0;
            s_nxt.evt = 1'b0;
        end else if (period_i && !s_r.evt) begin
            if (s_r.cnt + 4'h1 >= need_i) begin
                s_nxt.evt = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 4'h1;
            end
        end else if (need_i == 4'h0) begin
            s_nxt.evt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign event_o = s_r.evt;

    AST_BYP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        bypass_i |=> event_o == $past(cond_i))
        else $error("bypassed event does not follow condition");
endmodule
`default_nettype wire

// ---- hdl/alrc_map.svh ----
// constants, field layouts and decode values for the alternator config block
`ifndef ALRC_MAP_SVH
`define ALRC_MAP_SVH
`define ALRC_NVM_W        64
`define ALRC_RISE_LSB     0
`define ALRC_CUT_LSB      3
`define ALRC_NEG_LSB      5
`define ALRC_BZEN_BIT     8
`define ALRC_Q25_BIT      9
`define ALRC_BZ_LSB       10
`define ALRC_REPSRC_BIT   15
`define ALRC_SENS_BIT     16
`define ALRC_FT_LSB       17
`define ALRC_DLY_LSB      21
`define ALRC_SSSRC_BIT    23
`define ALRC_EMC_LSB      24
`define ALRC_BYP_BIT      30
`define ALRC_LRCNT_LSB    31
`define ALRC_RMDLY_LSB    34
`define ALRC_HOT_LSB      36
`define ALRC_LPF_BIT      39
`define ALRC_HONLY_BIT    40
`define ALRC_FMODE_BIT    41
`define ALRC_FEMR_LSB     42
`define ALRC_FBAND_LSB    45
`define ALRC_PHREP_LSB    47
`define ALRC_OVSD_BIT     49
`define ALRC_PROV_BIT     50
`define ALRC_CAP_LSB      51
`define ALRC_RISE_DEF     3'h2
`define ALRC_RISE_MAX     3'h6
`define ALRC_BZ_DEF       5'h10
`define ALRC_DLY_DEF      2'h2
`define ALRC_EMC_DEF      6'h0C
`define ALRC_LRCNT_DEF    3'h1
`define ALRC_RMDLY_DEF    2'h1
`define ALRC_HOT_DEF      3'h3
`define ALRC_CAP_DEF      3'h3
`define ALRC_OVSD_DEF     1'h1
`define ALRC_PROV_DEF     1'h1
`define ALRC_IDX_BASE     8'hFF
`define ALRC_RPM_4000     13'h0FA0
`define ALRC_DUTY_Q25     10'h0FA
`define ALRC_DUTY_ZERO    10'h000
`define ALRC_BZ_STEP      10'h008
`define ALRC_CLK_KHZ      250000
`define ALRC_MS_50        50
`define ALRC_MS_100       100
`define ALRC_MS_300       300
`endif

// ---- hdl/alrc_pkg.sv ----
// types shared by the alternator config block
package alrc_pkg;
    typedef enum logic [1:0] {
        ALRC_ST_IDLE = 2'h0,
        ALRC_ST_LOAD = 2'h1,
        ALRC_ST_RUN  = 2'h3
    } alrc_state_t;
endpackage

// ---- tb/alrc_cfg_tb.sv ----
// self-checking bench for the alternator config decode block
`timescale 1ns/1ns
`default_nettype none
`include "alrc_map.svh"
module alrc_cfg_tb;
    logic        mclk_i = 1'b0, rst_b_i = 1'b0, nvm_valid_i = 1'b0;
    logic [63:0] nvm_word_i = 64'h0;
    logic        lrc_active_i = 1'b0, pre_to_reg_i = 1'b0;
    logic        phase_reg_i = 1'b0, emergency_start_i = 1'b0;
    logic [9:0]  loop_duty_i = 10'h123, applied_duty_i = 10'h2A5;
    logic [9:0]  filt_duty_i = 10'h0C8, raw_duty_i = 10'h31E;
    logic [9:0]  phase_sample_i = 10'h000;
    logic        phase_period_i = 1'b0, lrc_request_i = 1'b0;
    logic        speed_above_lrc_i = 1'b0, speed_above_start_i = 1'b0;
    logic        speed_above_hot_i = 1'b0, pwm_en = 1'b0;
    logic [12:0] prog_start_rpm_i = 13'h0BB8;
    logic [4:0]  lin_code = 5'h00, lin_blind_zone_i;
    logic        pwm_period_i, cfg_ready_o, lrc_start_o, lrc_speed_event_o;
    logic        start_speed_event_o, hot_start_event_o, phase_high_only_o;
    logic        overlimit_shutdown_enable_o, phase_reg_ov_disable_o;
    logic [2:0]  lrc_rise_time_s_o, lrc_neg_gradient_time_o;
    logic [2:0]  adaptive_floor_code_o;
    logic [12:0] lrc_cutoff_rpm_o, self_start_rpm_o;
    logic [9:0]  lrc_start_duty_o, lin_duty_o, lrc_cmp_duty_o;
    logic [9:0]  phase_filt_o, phase_reg_duty_cap_o;
    logic [3:0]  duty_filter_time_sel_o, pwm_cnt;
    logic [7:0]  emergency_speed_idx_o;
    logic [12:0] cut_rpm [4] = '{13'h0BB8, 13'h0FA0, 13'h12C0, 13'h1770};
    logic [9:0]  cap_tab [8] = '{10'h037, 10'h078, 10'h0B4, 10'h0F0,
                                 10'h136, 10'h172, 10'h1AE, 10'h1F4};
    int          miscompares = 0, n_checks = 0;
    always #2 mclk_i = ~mclk_i;
    alrc_cfg u_dut (.mclk_i, .rst_b_i, .nvm_word_i, .nvm_valid_i,
        .lin_blind_zone_i, .lrc_active_i, .pre_to_reg_i, .phase_reg_i,
        .emergency_start_i, .loop_duty_i, .applied_duty_i, .filt_duty_i,
        .raw_duty_i, .phase_period_i, .speed_above_lrc_i,
        .speed_above_start_i, .speed_above_hot_i, .prog_start_rpm_i,
        .phase_sample_i, .pwm_period_i, .lrc_request_i, .cfg_ready_o,
        .lrc_rise_time_s_o, .lrc_cutoff_rpm_o, .lrc_neg_gradient_time_o,
        .lrc_start_duty_o, .lin_duty_o, .lrc_cmp_duty_o,
        .duty_filter_time_sel_o, .lrc_start_o, .self_start_rpm_o,
        .emergency_speed_idx_o, .lrc_speed_event_o, .start_speed_event_o,
        .hot_start_event_o, .phase_filt_o, .phase_high_only_o,
        .adaptive_floor_code_o, .overlimit_shutdown_enable_o,
        .phase_reg_ov_disable_o, .phase_reg_duty_cap_o);
    alrc_ecu_model u_ecu (.mclk_i, .rst_b_i, .pwm_en_i(pwm_en),
        .lin_code_i(lin_code), .pwm_period_o(pwm_period_i),
        .lin_blind_zone_o(lin_blind_zone_i), .pwm_cnt_o(pwm_cnt));

    task automatic check(input string nm, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // outputs are read just after an edge, before that edge's updates land
    task automatic load(input logic [63:0] w);
        int k;
        rst_b_i <= 1'b0;
        nvm_valid_i <= 1'b0;
        cyc(2);
        rst_b_i <= 1'b1;
        nvm_word_i <= w;
        cyc(2);
        nvm_valid_i <= 1'b1;
        k = 0;
        while (cfg_ready_o !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        check("cfg_ready", cfg_ready_o, 16'h1);
        cyc(2);
    endtask
    function automatic logic [63:0] dflt();
        logic [63:0] w;
        w = 64'h0;
        w[`ALRC_RISE_LSB +: 3] = 3'h2;
        w[`ALRC_BZ_LSB +: 5] = 5'h10;
        w[`ALRC_DLY_LSB +: 2] = 2'h2;
        w[`ALRC_EMC_LSB +: 6] = 6'h0C;
        w[`ALRC_LRCNT_LSB +: 3] = 3'h1;
        w[`ALRC_RMDLY_LSB +: 2] = 2'h1;
        w[`ALRC_HOT_LSB +: 3] = 3'h3;
        w[`ALRC_FEMR_LSB +: 3] = 3'h1;
        w[`ALRC_OVSD_BIT] = 1'b1;
        w[`ALRC_PROV_BIT] = 1'b1;
        w[`ALRC_CAP_LSB +: 3] = 3'h3;
        return w;
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        finish_test();
    end

    initial begin
        int i, k;
        logic [63:0] w;
        logic [4:0] bz;
        for (i = 0; i < 8; i++) begin
            w = dflt();
            w[`ALRC_RISE_LSB +: 3] = 3'(i);
            w[`ALRC_CUT_LSB +: 2] = 2'(i);
            w[`ALRC_NEG_LSB +: 3] = 3'(i);
            w[`ALRC_BZEN_BIT] = i[2];
            w[`ALRC_Q25_BIT] = i[1] & i[0];
            w[`ALRC_BZ_LSB +: 5] = 5'(i * 4 + 3);
            w[`ALRC_REPSRC_BIT] = i[1];
            w[`ALRC_SENS_BIT] = i[0];
            w[`ALRC_FT_LSB +: 4] = 4'(i * 2 + i[0]);
            w[`ALRC_SSSRC_BIT] = i[0];
            w[`ALRC_EMC_LSB +: 6] = 6'(i * 9);
            w[`ALRC_HONLY_BIT] = i[0];
            w[`ALRC_FMODE_BIT] = i[1];
            w[`ALRC_FEMR_LSB +: 3] = 3'(7 - i);
            w[`ALRC_FBAND_LSB +: 2] = 2'(i);
            w[`ALRC_PHREP_LSB +: 2] = 2'(i);
            w[`ALRC_OVSD_BIT] = i[1];
            w[`ALRC_PROV_BIT] = i[2];
            w[`ALRC_CAP_LSB +: 3] = 3'(i);
            lin_code <= 5'(31 - i);
            load(w);
            lrc_active_i <= 1'b1;
            pre_to_reg_i <= 1'b1;
            phase_reg_i <= 1'b0;
            emergency_start_i <= 1'b0;
            nvm_word_i <= ~w;
            cyc(3);
            bz = i[2] ? 5'(31 - i) : 5'(i * 4 + 3);
            check("rise", lrc_rise_time_s_o, 16'((i == 7) ? 3 : i + 1));
            check("cutoff", lrc_cutoff_rpm_o, cut_rpm[i % 4]);
            check("neg_grad", lrc_neg_gradient_time_o, 16'(i));
            check("start_duty", lrc_start_duty_o, (i[1] & i[0]) ? 10'h0FA
                  : {2'h0, bz, 3'h0});
            check("lrc_report", lin_duty_o,
                  i[1] ? applied_duty_i : loop_duty_i);
            check("cmp_duty", lrc_cmp_duty_o,
                  i[0] ? raw_duty_i : filt_duty_i);
            check("filt_time", duty_filter_time_sel_o, 16'(i * 2 + i[0]));
            check("self_start", self_start_rpm_o,
                  i[0] ? 13'h0FA0 : prog_start_rpm_i);
            check("emerg_idx", emergency_speed_idx_o, 16'(255 - 36 * i));
            check("high_only", phase_high_only_o, 16'(i[0]));
            check("floor_norm", adaptive_floor_code_o,
                  i[1] ? 16'(7 - i) : 16'(i % 4));
            check("ov_sd", overlimit_shutdown_enable_o, 16'(i[1]));
            check("ov_dis", phase_reg_ov_disable_o, 16'(i[2]));
            check("duty_cap", phase_reg_duty_cap_o, cap_tab[i]);
            lrc_active_i <= 1'b0;
            phase_reg_i <= 1'b1;
            emergency_start_i <= 1'b1;
            cyc(3);
            check("ph_report", lin_duty_o, (i % 4 == 0) ? loop_duty_i
                  : (i % 4 == 1) ? 10'h0FA : (i % 4 == 2) ? 10'h000
                  : applied_duty_i);
            check("floor_emerg", adaptive_floor_code_o, 16'(7 - i));
            check("rise_held", lrc_rise_time_s_o,
                  16'((i == 7) ? 3 : i + 1));
            phase_reg_i <= 1'b0;
            emergency_start_i <= 1'b0;
        end
        for (i = 0; i < 4; i++) begin
            w = dflt();
            w[`ALRC_DLY_LSB +: 2] = 2'(i);
            load(w);
            lrc_request_i <= 1'b1;
            pwm_en <= 1'b1;
            k = 0;
            while (lrc_start_o !== 1'b1 && k < 200) begin
                cyc(1);
                k++;
            end
            check("start_pulse", lrc_start_o, 16'h1);
            check("start_delay", pwm_cnt, 16'(i));
            lrc_request_i <= 1'b0;
            pwm_en <= 1'b0;
        end
        // need five periods for the lrc event, three for hot start
        w = dflt();
        w[`ALRC_LRCNT_LSB +: 3] = 3'h2;
        w[`ALRC_RMDLY_LSB +: 2] = 2'h0;
        load(w);
        speed_above_lrc_i <= 1'b1;
        speed_above_hot_i <= 1'b1;
        for (i = 1; i < 7; i++) begin
            phase_period_i <= 1'b1;
            cyc(1);
            phase_period_i <= 1'b0;
            cyc(3);
            check("lrc_event", lrc_speed_event_o, 16'(i >= 5));
            check("hot_event", hot_start_event_o, 16'(i >= 3));
        end
        w[`ALRC_BYP_BIT] = 1'b1;
        load(w);
        speed_above_start_i <= 1'b1;
        cyc(3);
        check("byp_lrc", lrc_speed_event_o, 16'h1);
        check("byp_hot", hot_start_event_o, 16'h1);
        check("start_evt", start_speed_event_o, 16'h1);
        speed_above_start_i <= 1'b0;
        cyc(3);
        check("start_gone", start_speed_event_o, 16'h0);
        speed_above_lrc_i <= 1'b0;
        speed_above_hot_i <= 1'b0;
        phase_sample_i <= 10'h200;
        load(dflt());
        check("ph_pass", phase_filt_o, 16'h200);
        w = dflt();
        w[`ALRC_LPF_BIT] = 1'b1;
        load(w);
        cyc(40);
        check("ph_lpf_in", phase_filt_o, 16'h200);
        phase_sample_i <= 10'h100;
        cyc(2);
        check("ph_lpf_step", 16'(phase_filt_o !== 10'h100), 16'h1);
        cyc(40);
        check("ph_lpf_out", phase_filt_o, 16'h100);
        finish_test();
    end
endmodule
`default_nettype wire

// ---- tb/alrc_ecu_model.sv ----
// engine-side model: pwm period pulses and the blind zone code sent over lin
`timescale 1ns/1ns
`default_nettype none
module alrc_ecu_model #(
    parameter int PWM_DIV = 8
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       pwm_en_i,
    input  wire logic [4:0] lin_code_i,
    output var  logic       pwm_period_o,
    output var  logic [4:0] lin_blind_zone_o,
    output var  logic [3:0] pwm_cnt_o
);
    logic [7:0] div_r;
    // lin frame content is a level, held until the next frame changes it
    assign lin_blind_zone_o = lin_code_i;
    // first pulse comes a whole period after enable, so no pulse is early
    assign pwm_period_o = pwm_en_i && (div_r == 8'(PWM_DIV - 1));
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !pwm_en_i) begin
            div_r <= 8'h00;
            pwm_cnt_o <= 4'h0;
        end else begin
            div_r <= pwm_period_o ? 8'h00 : div_r + 8'h01;
            pwm_cnt_o <= pwm_cnt_o + {3'h0, pwm_period_o};
        end
    end
endmodule
`default_nettype wire
